// *** verilog/dtc_pkg.sv ***
package dtc_pkg;
    localparam int NUM_CH    = 8;
    localparam int NUM_TGP   = 3;
    localparam int CODE_W    = 16;
    localparam int SPAN_W    = 3;
    // Span code 0 is the 0 V to 5 V range
    localparam logic [2:0]  SPAN_0_5V   = 3'h0;
    localparam logic [15:0] ZERO_CODE   = 16'h0000;
    localparam logic [7:0]  EN_RESET    = 8'h00;
    localparam logic [1:0]  MODE_RESET  = 2'h0;
    localparam logic        EXTREF_RST  = 1'b0;
    // Edges after reset release before the strap has crossed the synchroniser
    localparam logic [1:0]  STRAP_WAIT  = 2'h2;
    typedef enum logic [1:0] {DTC_MODE_TOGGLE, DTC_MODE_DITHER, DTC_MODE_OFF} dtc_mode_e;
endpackage : dtc_pkg

// *** verilog/dtc_sync_if.sv ***
`timescale 1ns/1ps
interface dtc_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport syncer (input raw, output q, output rise, output fall);
    modport user   (output raw, input q, input rise, input fall);
endinterface : dtc_sync_if

// *** verilog/dtc_sync.sv ***
`timescale 1ns/1ps
module dtc_sync #(
    parameter int W = 1
) (
    input  wire logic  clk_i,
    input  wire logic  reset_i,
    dtc_sync_if.syncer s
);
    logic [W-1:0] meta;
    logic [W-1:0] stage;
    logic [W-1:0] last;

    // Two stages before any logic; edges come from stage two and three only
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta  <= '0;
            stage <= '0;
            last  <= '0;
        end
        else
        begin
            meta  <= s.raw;
            stage <= meta;
            last  <= stage;
        end
    end

    assign s.q    = stage;
    assign s.rise = stage & ~last;
    assign s.fall = ~stage & last;
endmodule : dtc_sync

// *** verilog/dtc_ctrl.sv ***
`timescale 1ns/1ps
module dtc_ctrl #(
    parameter int NUM_CH  = dtc_pkg::NUM_CH,
    parameter int NUM_TGP = dtc_pkg::NUM_TGP,
    parameter int CODE_W  = dtc_pkg::CODE_W
) (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic [NUM_TGP-1:0]         toggle_pin_i,
    input  wire logic                       async_clear_n_i,
    input  wire logic                       chip_select_load_i,
    input  wire logic                       bandgap_comp_pin_i,
    input  wire logic                       over_temp_i,
    input  wire logic                       serial_error_i,
    input  wire logic                       cmd_valid_i,
    input  wire logic [NUM_CH-1:0]          cmd_enable_i,
    input  wire logic [NUM_CH*2-1:0]        cmd_tgp_sel_i,
    input  wire dtc_pkg::dtc_mode_e         cmd_mode_i,
    input  wire logic                       cmd_ext_ref_i,
    input  wire logic [NUM_CH*CODE_W-1:0]   reg_a_i,
    input  wire logic [NUM_CH*CODE_W-1:0]   reg_b_i,
    input  wire logic [NUM_CH*CODE_W-1:0]   dither_code_i,
    output logic      [NUM_CH*CODE_W-1:0]   dac_code_o,
    output logic      [NUM_CH*3-1:0]        span_o,
    output logic      [NUM_CH-1:0]          toggle_dither_enable_o,
    output dtc_pkg::dtc_mode_e              mode_o,
    output logic                            fault_o,
    output logic                            fault_oe_n_o,
    output logic                            int_ref_on_o,
    output logic                            ref_oe_n_o,
    output logic                            cmd_exec_o
);
    if (NUM_CH < 1 || NUM_CH > 8 || NUM_TGP < 1 || NUM_TGP > 4 || CODE_W < 1 || CODE_W > 16)
    begin : g_bad_params
        $error("dtc_ctrl: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers (toggle, clear, chip-select/load, strap)
    localparam int SW = NUM_TGP + 3;
    dtc_sync_if #(.W(SW)) sif ();
    assign sif.raw = {bandgap_comp_pin_i, chip_select_load_i, async_clear_n_i, toggle_pin_i};
    dtc_sync #(.W(SW)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .s       (sif)
    );

    logic [NUM_TGP-1:0] tgp_rise;
    logic [NUM_TGP-1:0] tgp_fall;
    logic               clr_active;
    logic               csld_rise;
    logic               comp_low;
    assign tgp_rise   = sif.rise[NUM_TGP-1:0];
    assign tgp_fall   = sif.fall[NUM_TGP-1:0];
    assign clr_active = ~sif.q[NUM_TGP];
    assign csld_rise  = sif.rise[NUM_TGP+1];
    assign comp_low   = ~sif.q[NUM_TGP+2];

    // Channel to toggle pin mapping; a code past the pin count falls back to pin 0
    function automatic logic [1:0] pin_of(input logic [NUM_CH*2-1:0] sel, input int ch);
        logic [1:0] p;
        p = sel[ch*2 +: 2];
        if (int'(p) >= NUM_TGP)
            p = 2'h0;
        return p;
    endfunction : pin_of

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [NUM_CH*2-1:0] tgp_sel;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            toggle_dither_enable_o <= dtc_pkg::EN_RESET[NUM_CH-1:0];
            mode_o                 <= dtc_pkg::DTC_MODE_TOGGLE;
            tgp_sel                <= '0;
        end
        else if (clr_active)
        begin
            toggle_dither_enable_o <= dtc_pkg::EN_RESET[NUM_CH-1:0];
            mode_o                 <= dtc_pkg::DTC_MODE_TOGGLE;
            tgp_sel                <= '0;
        end
        else if (cmd_valid_i && csld_rise)
        begin
            toggle_dither_enable_o <= cmd_enable_i;
            mode_o                 <= cmd_mode_i;
            tgp_sel                <= cmd_tgp_sel_i;
        end
    end

    // Execute strobe marks the command taken on chip-select/load rising
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            cmd_exec_o <= 1'b0;
        else
            cmd_exec_o <= csld_rise & cmd_valid_i & ~clr_active;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel DAC registers and spans
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [1:0] pin;
            assign pin = pin_of(tgp_sel, g);
            always_ff @(posedge clk_i or posedge reset_i)
            begin
                if (reset_i)
                begin
                    dac_code_o[g*CODE_W +: CODE_W] <= dtc_pkg::ZERO_CODE[CODE_W-1:0];
                    span_o[g*3 +: 3]               <= dtc_pkg::SPAN_0_5V;
                end
                else if (clr_active)
                begin
                    // Clear wins over any edge in the same cycle
                    dac_code_o[g*CODE_W +: CODE_W] <= dtc_pkg::ZERO_CODE[CODE_W-1:0];
                    span_o[g*3 +: 3]               <= dtc_pkg::SPAN_0_5V;
                end
                else if (toggle_dither_enable_o[g])
                begin
                    unique case (mode_o)
                        dtc_pkg::DTC_MODE_TOGGLE:
                        begin
                            if (tgp_fall[pin])
                                dac_code_o[g*CODE_W +: CODE_W] <= reg_a_i[g*CODE_W +: CODE_W];
                            else if (tgp_rise[pin])
                                dac_code_o[g*CODE_W +: CODE_W] <= reg_b_i[g*CODE_W +: CODE_W];
                        end
                        dtc_pkg::DTC_MODE_DITHER:
                        begin
                            if (tgp_rise[pin])
                                dac_code_o[g*CODE_W +: CODE_W] <= dither_code_i[g*CODE_W +: CODE_W];
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Fault: latched, set wins over release; oe_n low while pulling low
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            fault_o      <= 1'b0;
            fault_oe_n_o <= 1'b1;
        end
        else if (over_temp_i || serial_error_i)
        begin
            fault_o      <= 1'b0;
            fault_oe_n_o <= 1'b0;
        end
        else if (csld_rise)
        begin
            fault_o      <= 1'b0;
            fault_oe_n_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference select; strap sampled once after reset release
    logic       strap_done;
    logic       ext_ref;
    logic [1:0] strap_cnt;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            strap_done <= 1'b0;
            strap_cnt  <= 2'h0;
            ext_ref    <= dtc_pkg::EXTREF_RST;
        end
        else if (!strap_done)
        begin
            // Waits for the synchroniser to fill before trusting the strap
            if (strap_cnt == dtc_pkg::STRAP_WAIT)
            begin
                strap_done <= 1'b1;
                ext_ref    <= comp_low;
            end
            else
                strap_cnt  <= strap_cnt + 2'h1;
        end
        else if (clr_active)
            ext_ref    <= dtc_pkg::EXTREF_RST;
        else if (cmd_valid_i && csld_rise)
            ext_ref    <= cmd_ext_ref_i;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            int_ref_on_o <= 1'b0;
            ref_oe_n_o   <= 1'b1;
        end
        else
        begin
            int_ref_on_o <= strap_done & ~ext_ref;
            ref_oe_n_o   <= ~(strap_done & ~ext_ref);
        end
    end
endmodule : dtc_ctrl

// *** dv/dtc_host_model.sv ***
`timescale 1ns/1ps
module dtc_host_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] level_i,
    output logic      [2:0] toggle_pin_o
);
    // Registered so pin edges land on a clock edge, one cycle after level_i changes
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            toggle_pin_o <= 3'h0;
        else
            toggle_pin_o <= level_i;
    end
endmodule : dtc_host_model

// *** dv/dtc_ctrl_assertions.sv ***
`timescale 1ns/1ps
module dtc_ctrl_checker (
    input wire logic               clk_i,
    input wire logic               reset_i,
    input wire logic               async_clear_n_i,
    input wire logic               chip_select_load_i,
    input wire logic               over_temp_i,
    input wire logic               serial_error_i,
    input wire logic               cmd_valid_i,
    input wire logic               cmd_ext_ref_i,
    input wire logic [7:0]         cmd_enable_i,
    input wire logic [127:0]       dac_code_o,
    input wire logic [23:0]        span_o,
    input wire logic [7:0]         toggle_dither_enable_o,
    input wire dtc_pkg::dtc_mode_e mode_o,
    input wire logic               fault_oe_n_o,
    input wire logic               int_ref_on_o,
    input wire logic               ref_oe_n_o,
    input wire logic               cmd_exec_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    clear_zero_a: assert property (
        (!async_clear_n_i)[*4] |=> dac_code_o == '0 && span_o == '0) else $error("clear left codes");
    clear_regs_a: assert property (
        (!async_clear_n_i)[*4] |=> toggle_dither_enable_o == '0 && mode_o == dtc_pkg::DTC_MODE_TOGGLE)
        else $error("clear left control bits");
    over_temp_a: assert property (over_temp_i |=> !fault_oe_n_o) else $error("no heat fault");
    serial_err_a: assert property (serial_error_i |=> !fault_oe_n_o) else $error("no link fault");
    fault_release_a: assert property ($rose(fault_oe_n_o) |->
        $past(chip_select_load_i, 2) || $past(chip_select_load_i, 3) || $past(chip_select_load_i, 4))
        else $error("fault released without load edge");
    ref_pin_a: assert property (ref_oe_n_o != int_ref_on_o) else $error("ref drive mismatch");
    ref_cmd_a: assert property (cmd_exec_o |=> int_ref_on_o == !$past(cmd_ext_ref_i, 2))
        else $error("reference not switched");
    exec_pulse_a: assert property (cmd_exec_o |-> $past(cmd_valid_i) ##1 !cmd_exec_o)
        else $error("bad exec pulse");
    exec_load_a: assert property (cmd_exec_o |-> toggle_dither_enable_o == $past(cmd_enable_i))
        else $error("enables not loaded");
    unused_ch_a: assert property (async_clear_n_i[*5] ##0 !toggle_dither_enable_o[1]
        |=> $stable(dac_code_o[31:16])) else $error("disabled channel moved");
endmodule : dtc_ctrl_checker
bind dtc_ctrl dtc_ctrl_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .async_clear_n_i(async_clear_n_i),
    .chip_select_load_i(chip_select_load_i), .over_temp_i(over_temp_i), .serial_error_i(serial_error_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ext_ref_i(cmd_ext_ref_i), .cmd_enable_i(cmd_enable_i),
    .dac_code_o(dac_code_o), .span_o(span_o),
    .toggle_dither_enable_o(toggle_dither_enable_o), .mode_o(mode_o), .fault_oe_n_o(fault_oe_n_o),
    .int_ref_on_o(int_ref_on_o), .ref_oe_n_o(ref_oe_n_o), .cmd_exec_o(cmd_exec_o));

// *** dv/dtc_ctrl_test.sv ***
`timescale 1ns/1ps
module dtc_ctrl_test;
    localparam logic [127:0] MASK = {80'h0, 48'hFFFF0000FFFF};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] lvl = 3'h0;
    logic [2:0] tgp;
    logic clr_n = 1'b1, csld = 1'b0, ot = 1'b0, serr = 1'b0, cv = 1'b0;
    logic [7:0] en = 8'h00;
    logic comp = 1'b0, xr = 1'b0, fo;
    logic [15:0] tsel = 16'h0000;
    dtc_pkg::dtc_mode_e mode = dtc_pkg::DTC_MODE_OFF;
    logic [127:0] ra, rb, rd, dac;
    logic [23:0] span;
    logic [7:0] tde;
    dtc_pkg::dtc_mode_e mo;
    logic foe, iro, roe, exe;
    int miscompares = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    dtc_host_model host (.clk_i(clk_i), .reset_i(reset_i), .level_i(lvl), .toggle_pin_o(tgp));
    dtc_ctrl dut (.clk_i(clk_i), .reset_i(reset_i), .toggle_pin_i(tgp), .async_clear_n_i(clr_n),
        .chip_select_load_i(csld), .bandgap_comp_pin_i(comp), .over_temp_i(ot), .serial_error_i(serr),
        .cmd_valid_i(cv), .cmd_enable_i(en), .cmd_tgp_sel_i(tsel), .cmd_mode_i(mode),
        .cmd_ext_ref_i(xr), .reg_a_i(ra), .reg_b_i(rb), .dither_code_i(rd), .dac_code_o(dac),
        .span_o(span), .toggle_dither_enable_o(tde), .mode_o(mo), .fault_o(fo), .fault_oe_n_o(foe),
        .int_ref_on_o(iro), .ref_oe_n_o(roe), .cmd_exec_o(exe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask : step
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Load edge held 6 cycles so the synchroniser always catches it
    task automatic pulse_cs();
        csld <= 1'b1;
        step(6);
        csld <= 1'b0;
        step(6);
    endtask : pulse_cs
    task automatic cmd(input logic [7:0] e, input dtc_pkg::dtc_mode_e m);
        en <= e;
        mode <= m;
        cv <= 1'b1;
        pulse_cs();
        cv <= 1'b0;
    endtask : cmd
    task automatic pin(input logic [2:0] v);
        lvl <= v;
        step(8);
    endtask : pin
    task automatic pulse_cause(input bit heat);
        if (heat)
            ot <= 1'b1;
        else
            serr <= 1'b1;
        step(1);
        ot <= 1'b0;
        serr <= 1'b0;
        step(8);
    endtask : pulse_cause
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 8; i++)
        begin
            ra[i*16+:16] = 16'hA000 + 16'(i);
            rb[i*16+:16] = 16'hB000 + 16'(i);
            rd[i*16+:16] = 16'hD000 + 16'(i);
        end
        step(20);
        reset_i <= 1'b0;
        step(6);
        chk(iro, 1'b0);
        chk(roe, 1'b1);
        cmd(8'h05, dtc_pkg::DTC_MODE_TOGGLE);
        chk(tde, 8'h05);
        chk(iro, 1'b1);
        chk(roe, 1'b0);
        pin(3'h1);
        chk(dac, rb & MASK);
        pin(3'h0);
        chk(dac, ra & MASK);
        cmd(8'h05, dtc_pkg::DTC_MODE_DITHER);
        pin(3'h1);
        chk(dac, rd & MASK);
        pin(3'h0);
        chk(dac, rd & MASK);
        pulse_cause(1'b1);
        chk(foe, 1'b0);
        chk(fo, 1'b0);
        pulse_cs();
        chk(foe, 1'b1);
        pulse_cause(1'b0);
        chk(foe, 1'b0);
        clr_n <= 1'b0;
        step(5);
        pin(3'h1);
        chk(dac, '0);
        chk(span, '0);
        chk(tde, '0);
        chk(mo, dtc_pkg::DTC_MODE_TOGGLE);
        // Second reset with the strap open: internal reference comes up by default
        reset_i <= 1'b1;
        clr_n <= 1'b1;
        comp <= 1'b1;
        lvl <= 3'h0;
        step(2);
        reset_i <= 1'b0;
        step(6);
        chk(iro, 1'b1);
        chk(roe, 1'b0);
        xr <= 1'b1;
        cmd(8'h05, dtc_pkg::DTC_MODE_OFF);
        chk(mo, dtc_pkg::DTC_MODE_OFF);
        chk(iro, 1'b0);
        chk(roe, 1'b1);
        pin(3'h1);
        chk(dac, '0);
        tsel <= 16'h0010;
        cmd(8'h05, dtc_pkg::DTC_MODE_TOGGLE);
        pin(3'h3);
        chk(dac, rb & {80'h0, 48'hFFFF00000000});
        finish_test();
    end
    initial
    begin
        #20us;
        miscompares++;
        finish_test();
    end
endmodule : dtc_ctrl_test
